// ===== core/dubp_pkg.sv
`default_nettype none

package dubp_pkg;

   // Host bus widths
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned ADDR_W      = 3;

   // Pin synchroniser depth
   localparam int unsigned SYNC_STAGES = 3;

   // Field positions in the synchronised pin bundle
   localparam int unsigned PIN_W       = 15;
   localparam int unsigned POS_CS_N    = 14;
   localparam int unsigned POS_RD_N    = 13;
   localparam int unsigned POS_WR_N    = 12;
   localparam int unsigned POS_PICK    = 11;
   localparam int unsigned POS_ADDR    = 8;
   localparam int unsigned POS_DATA    = 0;

   // Bundle reset value: chip select and both strobes idle high
   localparam logic [PIN_W-1:0] PIN_RST = 15'h7000;

   // Channel-select level that picks channel A
   localparam logic PICK_CHAN_A = 1'b1;

   // Cycles from a channel read request to valid read data
   localparam int unsigned RD_LAT_CYC = 1;

   // Reset values of the pass-through status outputs
   localparam logic IRQ_RST      = 1'b0;
   localparam logic TX_SPACE_RST = 1'b1;

   // Access offered to one UART channel's register file
   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dubp_chan_acc_t;

   // Status returned by one UART channel
   typedef struct packed {
      logic              irq;
      logic              tx_space_n;
      logic [DATA_W-1:0] rdata;
   } dubp_chan_stat_t;

   // Bus sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } dubp_state_t;

endpackage : dubp_pkg

`default_nettype wire

// ===== core/dubp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module dubp_pin_sync #(
   parameter int unsigned   WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             sys_rst_i,
   // Raw pins and filtered result
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] pin_o
);

   // One three-stage chain per bit
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic ff1_r;
         logic ff2_r;
         logic ff3_r;
         logic q_r;

         // First stage feeds only the second
         always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               ff1_r <= RST_VAL[g];
               ff2_r <= RST_VAL[g];
               ff3_r <= RST_VAL[g];
            end else begin
               ff1_r <= pin_i[g];
               ff2_r <= ff1_r;
               ff3_r <= ff2_r;
            end
         end

         // Accept a change only once stages two and three agree
         always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               q_r <= RST_VAL[g];
            end else if (ff2_r == ff3_r) begin
               q_r <= ff3_r;
            end
         end

         assign pin_o[g] = q_r;
      end
   endgenerate

endmodule : dubp_pin_sync

`default_nettype wire

// ===== core/dubp_host_port.sv
// Overview of operation
// - A falling read strobe starts a read of the selected register and drives its byte out.
// - Write strobe falling opens a write; its rise stores the bus byte in the selected register.
// - Transfers happen only while chip select is low, and then channel-select picks the channel.
// - With chip select low, channel-select low means channel B and high means channel A.
// - With the broadcast bit set, one write updates the addressed register in both channels.
// - Each channel has its own active-high interrupt output, high while it asks for service.
// - Each channel has its own active-low transmitter-ready output for its transmit buffer.
// - The data bus is eight bits, two-way, driven only during reads and received during writes.
// - The three select lines pick one of eight registers in the chosen channel.
`timescale 1ns/1ps
`default_nettype none

module dubp_host_port (
   // Clock and reset
   input  wire logic                             sys_clk_i,
   input  wire logic                             sys_rst_i,
   // Host bus pins
   input  wire logic                             cs_n_i,
   input  wire logic                             read_strobe_n_i,
   input  wire logic                             write_strobe_n_i,
   input  wire logic                             channel_pick_i,
   input  wire logic [dubp_pkg::ADDR_W-1:0]      reg_select_lines_i,
   input  wire logic [dubp_pkg::DATA_W-1:0]      host_data_bus_i,
   output logic      [dubp_pkg::DATA_W-1:0]      host_data_bus_o,
   output logic                                  host_data_bus_oe_o,
   // Broadcast-write bit of the alternate function register
   input  wire logic                             alt_function_bcast_i,
   // Channel register-file side
   output dubp_pkg::dubp_chan_acc_t              chan_a_acc_o,
   output dubp_pkg::dubp_chan_acc_t              chan_b_acc_o,
   input  wire dubp_pkg::dubp_chan_stat_t        chan_a_stat_i,
   input  wire dubp_pkg::dubp_chan_stat_t        chan_b_stat_i,
   // Per-channel status pins
   output logic                                  irq_chan_a_o,
   output logic                                  irq_chan_b_o,
   output logic                                  tx_space_a_n_o,
   output logic                                  tx_space_b_n_o
);

   // Synchronised pin bundle
   logic [dubp_pkg::PIN_W-1:0]  pins_raw;
   logic [dubp_pkg::PIN_W-1:0]  pins;
   logic                        cs_n;
   logic                        rd_n;
   logic                        wr_n;
   logic                        pick;
   logic [dubp_pkg::ADDR_W-1:0] addr;
   logic [dubp_pkg::DATA_W-1:0] wdata;

   // Edge history and sequencer state
   logic                        rd_n_prev_r;
   logic                        wr_n_prev_r;
   dubp_pkg::dubp_state_t       state_r;
   dubp_pkg::dubp_state_t       state_nxt;
   logic                        sel_a_r;
   logic [3:0]                  lat_cnt_r;

   // Decoded events
   logic                        rd_fall;
   logic                        rd_rise;
   logic                        wr_fall;
   logic                        wr_rise;
   logic                        start_rd;
   logic                        start_wr;
   logic                        end_rd;
   logic                        commit_wr;
   logic                        bcast;
   logic                        rd_data_due;

   assign pins_raw = {cs_n_i, read_strobe_n_i, write_strobe_n_i, channel_pick_i,
                      reg_select_lines_i, host_data_bus_i};

   // All host pins are asynchronous to the core clock
   dubp_pin_sync #(
      .WIDTH   (dubp_pkg::PIN_W),
      .RST_VAL (dubp_pkg::PIN_RST)
   ) u_pin_sync (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (pins_raw),
      .pin_o     (pins)
   );

   assign cs_n  = pins[dubp_pkg::POS_CS_N];
   assign rd_n  = pins[dubp_pkg::POS_RD_N];
   assign wr_n  = pins[dubp_pkg::POS_WR_N];
   assign pick  = pins[dubp_pkg::POS_PICK];
   assign addr  = pins[dubp_pkg::POS_ADDR +: dubp_pkg::ADDR_W];
   assign wdata = pins[dubp_pkg::POS_DATA +: dubp_pkg::DATA_W];

   // Strobe edge history
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_n_prev_r <= 1'b1;
         wr_n_prev_r <= 1'b1;
      end else begin
         rd_n_prev_r <= rd_n;
         wr_n_prev_r <= wr_n;
      end
   end

   // Edges count only while the chip is selected
   assign rd_fall   = rd_n_prev_r & ~rd_n;
   assign rd_rise   = ~rd_n_prev_r & rd_n;
   assign wr_fall   = wr_n_prev_r & ~wr_n;
   assign wr_rise   = ~wr_n_prev_r & wr_n;
   assign start_rd  = rd_fall & ~cs_n & (state_r == dubp_pkg::ST_IDLE);
   assign start_wr  = wr_fall & ~cs_n & ~start_rd
                      & (state_r == dubp_pkg::ST_IDLE);
   assign end_rd    = rd_rise | cs_n;
   assign commit_wr = wr_rise & ~cs_n;
   assign bcast     = alt_function_bcast_i;

   // Sequencer next state; a deselect mid-write drops the write
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dubp_pkg::ST_IDLE: begin
            if (start_rd) begin
               state_nxt = dubp_pkg::ST_READ;
            end else if (start_wr) begin
               state_nxt = dubp_pkg::ST_WRITE;
            end
         end
         dubp_pkg::ST_READ: begin
            if (end_rd) begin
               state_nxt = dubp_pkg::ST_IDLE;
            end
         end
         dubp_pkg::ST_WRITE: begin
            if (wr_rise | cs_n) begin
               state_nxt = dubp_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = dubp_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= dubp_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Channel frozen at the opening edge so a late pick change cannot split a transfer
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sel_a_r <= 1'b0;
      end else if (start_rd | start_wr) begin
         sel_a_r <= (pick == dubp_pkg::PICK_CHAN_A);
      end
   end

   // Read data arrives a fixed latency after the request
   assign rd_data_due = (lat_cnt_r == 4'(dubp_pkg::RD_LAT_CYC));

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lat_cnt_r <= '0;
      end else if (start_rd) begin
         lat_cnt_r <= 4'h1;
      end else if (lat_cnt_r != 4'h0) begin
         lat_cnt_r <= rd_data_due ? 4'h0 : 4'(lat_cnt_r + 4'h1);
      end
   end

   // Channel A request: one-cycle read or write pulses
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         chan_a_acc_o <= '0;
      end else begin
         chan_a_acc_o.rd <= start_rd & (pick == dubp_pkg::PICK_CHAN_A);
         chan_a_acc_o.wr <= (state_r == dubp_pkg::ST_WRITE) & commit_wr
                            & (sel_a_r | bcast);
         if (start_rd) begin
            chan_a_acc_o.addr <= addr;
         end else if (commit_wr) begin
            chan_a_acc_o.addr  <= addr;
            chan_a_acc_o.wdata <= wdata;
         end
      end
   end

   // Channel B mirrors A with the opposite pick level
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         chan_b_acc_o <= '0;
      end else begin
         chan_b_acc_o.rd <= start_rd & (pick != dubp_pkg::PICK_CHAN_A);
         chan_b_acc_o.wr <= (state_r == dubp_pkg::ST_WRITE) & commit_wr
                            & (~sel_a_r | bcast);
         if (start_rd) begin
            chan_b_acc_o.addr <= addr;
         end else if (commit_wr) begin
            chan_b_acc_o.addr  <= addr;
            chan_b_acc_o.wdata <= wdata;
         end
      end
   end

   // Read byte captured once, then held steady until the strobe rises
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         host_data_bus_o <= '0;
      end else if (rd_data_due & (state_r == dubp_pkg::ST_READ)) begin
         host_data_bus_o <= sel_a_r ? chan_a_stat_i.rdata
                                    : chan_b_stat_i.rdata;
      end
   end

   // Drive the bus only inside a selected read
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         host_data_bus_oe_o <= 1'b0;
      end else if (end_rd | (state_r != dubp_pkg::ST_READ)) begin
         host_data_bus_oe_o <= 1'b0;
      end else if (rd_data_due) begin
         host_data_bus_oe_o <= 1'b1;
      end
   end

   // Status pins registered so every output leaves a flop
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_chan_a_o   <= dubp_pkg::IRQ_RST;
         irq_chan_b_o   <= dubp_pkg::IRQ_RST;
         tx_space_a_n_o <= dubp_pkg::TX_SPACE_RST;
         tx_space_b_n_o <= dubp_pkg::TX_SPACE_RST;
      end else begin
         irq_chan_a_o   <= chan_a_stat_i.irq;
         irq_chan_b_o   <= chan_b_stat_i.irq;
         tx_space_a_n_o <= chan_a_stat_i.tx_space_n;
         tx_space_b_n_o <= chan_b_stat_i.tx_space_n;
      end
   end

endmodule : dubp_host_port

`default_nettype wire

// ===== bench/dubp_host_port_chk.sv
`timescale 1ns/1ps
`default_nettype none

module dubp_host_port_chk (
   // Clock and reset
   input wire logic                      sys_clk_i,
   input wire logic                      sys_rst_i,
   // Host pins
   input wire logic                      cs_n_i,
   input wire logic                      read_strobe_n_i,
   input wire logic                      alt_function_bcast_i,
   input wire logic [7:0]                host_data_bus_o,
   input wire logic                      host_data_bus_oe_o,
   // Channel side and status
   input wire dubp_pkg::dubp_chan_acc_t  chan_a_acc_o,
   input wire dubp_pkg::dubp_chan_acc_t  chan_b_acc_o,
   input wire dubp_pkg::dubp_chan_stat_t chan_a_stat_i,
   input wire dubp_pkg::dubp_chan_stat_t chan_b_stat_i,
   input wire logic                      irq_chan_a_o,
   input wire logic                      irq_chan_b_o,
   input wire logic                      tx_space_a_n_o,
   input wire logic                      tx_space_b_n_o
);
   logic [3:0] idle_cnt_r;
   logic [3:0] cs_cnt_r;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   // Idle run lengths; saturate so long idles never wrap
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         idle_cnt_r <= 4'h0;
         cs_cnt_r   <= 4'h0;
      end else begin
         idle_cnt_r <= (cs_n_i || read_strobe_n_i) ? idle_cnt_r + (idle_cnt_r != 4'hF) : 4'h0;
         cs_cnt_r   <= cs_n_i ? cs_cnt_r + (cs_cnt_r != 4'hF) : 4'h0;
      end
   end

   AST_RD_PULSE: assert property ((chan_a_acc_o.rd || chan_b_acc_o.rd) |=>
      !(chan_a_acc_o.rd || chan_b_acc_o.rd)) else $error("read pulse too long");
   AST_RD_DATA_A: assert property (chan_a_acc_o.rd |-> ##[1:3]
      (host_data_bus_oe_o && host_data_bus_o == chan_a_stat_i.rdata)) else $error("bad A read");
   AST_RD_DATA_B: assert property (chan_b_acc_o.rd |-> ##[1:3]
      (host_data_bus_oe_o && host_data_bus_o == chan_b_stat_i.rdata)) else $error("bad B read");
   AST_RD_HOLD: assert property (host_data_bus_oe_o && !cs_n_i && !read_strobe_n_i |=>
      host_data_bus_oe_o) else $error("read byte dropped early");
   AST_RD_ONE_CHAN: assert property (!(chan_a_acc_o.rd && chan_b_acc_o.rd))
      else $error("read to both channels");
   AST_BCAST_BOTH: assert property ((chan_a_acc_o.wr || chan_b_acc_o.wr)
      && alt_function_bcast_i |-> chan_a_acc_o.wr && chan_b_acc_o.wr)
      else $error("broadcast missed a channel");
   AST_BOTH_NEEDS_BCAST: assert property (chan_a_acc_o.wr && chan_b_acc_o.wr |->
      alt_function_bcast_i) else $error("write reached both channels");
   AST_BUS_RELEASE: assert property (idle_cnt_r >= 4'h8 |-> !host_data_bus_oe_o)
      else $error("bus driven while idle");
   AST_NO_ACC_WO_CS: assert property (cs_cnt_r >= 4'h8 |->
      !(chan_a_acc_o.rd || chan_a_acc_o.wr || chan_b_acc_o.rd || chan_b_acc_o.wr))
      else $error("access without chip select");
   AST_IRQ_FOLLOW: assert property (!$past(sys_rst_i) |->
      irq_chan_a_o == $past(chan_a_stat_i.irq) && irq_chan_b_o == $past(chan_b_stat_i.irq))
      else $error("irq output wrong");
   AST_TX_FOLLOW: assert property (!$past(sys_rst_i) |->
      tx_space_a_n_o == $past(chan_a_stat_i.tx_space_n)
      && tx_space_b_n_o == $past(chan_b_stat_i.tx_space_n)) else $error("tx ready wrong");

   // Main traffic kinds
   COV_RD_A: cover property (chan_a_acc_o.rd);
   COV_RD_B: cover property (chan_b_acc_o.rd);
   COV_BCAST: cover property (chan_a_acc_o.wr && chan_b_acc_o.wr);
endmodule : dubp_host_port_chk

bind dubp_host_port dubp_host_port_chk i_dubp_host_port_chk (.sys_clk_i, .sys_rst_i, .cs_n_i,
   .read_strobe_n_i, .alt_function_bcast_i, .host_data_bus_o, .host_data_bus_oe_o, .chan_a_acc_o,
   .chan_b_acc_o, .chan_a_stat_i, .chan_b_stat_i, .irq_chan_a_o, .irq_chan_b_o, .tx_space_a_n_o,
   .tx_space_b_n_o);

`default_nettype wire

// ===== bench/dubp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module dubp_host_model (
   // Clock
   input  wire logic       sys_clk_i,
   // Bus pins toward the port
   output logic            cs_n_o,
   output logic            rd_n_o,
   output logic            wr_n_o,
   output logic            pick_o,
   output logic [2:0]      addr_o,
   output logic [7:0]      dout_o,
   output logic            drv_o,
   input  wire logic [7:0] din_i
);
   // Idle bus at time zero
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      pick_o = 1'b0;
      addr_o = 3'h0;
      dout_o = 8'h00;
      drv_o  = 1'b0;
   end

   // One transfer; long holds since the port filters every pin
   task automatic cycle(input logic wr, input logic sel, input logic pick,
                        input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge sys_clk_i);
      cs_n_o = !sel;
      pick_o = pick;
      addr_o = a;
      dout_o = d;
      drv_o  = wr;
      repeat (3) @(negedge sys_clk_i);
      rd_n_o = wr;
      wr_n_o = !wr;
      repeat (10) @(negedge sys_clk_i);
      q      = din_i;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      cs_n_o = 1'b1;
      drv_o  = 1'b0;
      repeat (2) @(negedge sys_clk_i);
   endtask : cycle
endmodule : dubp_host_model

`default_nettype wire

// ===== bench/dubp_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dubp_host_port_tb;
   logic                      sys_clk, sys_rst, cs_n, rd_n, wr_n, pick, drv, bcast, oe, p;
   logic                      irq_a, irq_b, txn_a, txn_b, irq_a_o, irq_b_o, txs_a_o, txs_b_o;
   logic [7:0]                dout, bus, last_bus, data_o, q, d;
   logic [2:0]                addr, a;
   logic [7:0]                mem_a [8];
   logic [7:0]                mem_b [8];
   dubp_pkg::dubp_chan_acc_t  acc_a, acc_b;
   dubp_pkg::dubp_chan_stat_t st_a, st_b;
   int                        exp_a [8];
   int                        exp_b [8];
   int                        n_errors, checks_done;

   dubp_host_model i_dubp_host_model (.sys_clk_i(sys_clk), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .wr_n_o(wr_n), .pick_o(pick), .addr_o(addr), .dout_o(dout), .drv_o(drv), .din_i(bus));
   dubp_host_port i_dubp_host_port (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .cs_n_i(cs_n),
      .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .channel_pick_i(pick),
      .reg_select_lines_i(addr), .host_data_bus_i(bus), .host_data_bus_o(data_o),
      .host_data_bus_oe_o(oe), .alt_function_bcast_i(bcast), .chan_a_acc_o(acc_a),
      .chan_b_acc_o(acc_b), .chan_a_stat_i(st_a), .chan_b_stat_i(st_b), .irq_chan_a_o(irq_a_o),
      .irq_chan_b_o(irq_b_o), .tx_space_a_n_o(txs_a_o), .tx_space_b_n_o(txs_b_o));

   // Undriven bus shows the inverse of its last value, never a stale byte
   assign bus = oe ? data_o : (drv ? dout : ~last_bus);
   always @(posedge sys_clk) last_bus <= bus;

   // Channel register files; read data follows the address at once
   always @(posedge sys_clk) begin
      if (acc_a.wr) mem_a[acc_a.addr] <= acc_a.wdata;
      if (acc_b.wr) mem_b[acc_b.addr] <= acc_b.wdata;
   end
   assign st_a = '{irq: irq_a, tx_space_n: txn_a, rdata: mem_a[acc_a.addr]};
   assign st_b = '{irq: irq_b, tx_space_n: txn_b, rdata: mem_b[acc_b.addr]};

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("Checks %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Run needs about 1100 cycles; cut a hang well beyond that
   initial begin
      #1_000_000;
      n_errors++;
      end_sim();
   end

   initial begin
      {sys_rst, bcast, irq_a, irq_b, txn_a, txn_b, last_bus} = {6'b100011, 8'h00};
      for (int i = 0; i < 8; i++) begin
         {mem_a[i], mem_b[i], exp_a[i], exp_b[i]} = '0;
      end
      void'($urandom(78));
      repeat (16) @(negedge sys_clk);
      sys_rst = 1'b0;
      check({7'h00, oe}, 8'h00);
      check({4'h0, irq_a_o, irq_b_o, txs_a_o, txs_b_o}, 8'h03);
      repeat (8) @(negedge sys_clk);
      // Fill every location of both channels, then a broadcast pair
      for (int i = 0; i < 18; i++) begin
         p = i[3];
         a = i[2:0];
         d = 8'($urandom);
         bcast = (i >= 16);
         i_dubp_host_model.cycle(1'b1, 1'b1, p, a, d, q);
         if (p || bcast) exp_a[a] = d;
         if (!p || bcast) exp_b[a] = d;
         check(mem_a[a], 8'(exp_a[a]));
         check(mem_b[a], 8'(exp_b[a]));
      end
      bcast = 1'b0;
      // Writes and reads without chip select change nothing
      for (int i = 0; i < 2; i++) begin
         a = 3'($urandom);
         i_dubp_host_model.cycle(i[0], 1'b0, 1'b1, a, 8'h5A, q);
         check(mem_a[a], 8'(exp_a[a]));
         check({7'h00, oe}, 8'h00);
      end
      // Random read-back, bus released afterwards
      for (int i = 0; i < 24; i++) begin
         p = 1'($urandom);
         a = 3'($urandom);
         i_dubp_host_model.cycle(1'b0, 1'b1, p, a, 8'h00, q);
         check(q, 8'(p ? exp_a[a] : exp_b[a]));
         check({7'h00, oe}, 8'h00);
      end
      for (int i = 0; i < 8; i++) begin
         check(mem_a[i], 8'(exp_a[i]));
         check(mem_b[i], 8'(exp_b[i]));
      end
      // Status pins per channel
      for (int i = 0; i < 8; i++) begin
         {irq_a, irq_b, txn_a, txn_b} = 4'($urandom);
         repeat (2) @(negedge sys_clk);
         check({6'h00, irq_a_o, irq_b_o}, {6'h00, irq_a, irq_b});
         check({6'h00, txs_a_o, txs_b_o}, {6'h00, txn_a, txn_b});
      end
      end_sim();
   end
endmodule : dubp_host_port_tb

`default_nettype wire
